// File: hw/adc_result_readout.sv
// Result readout of a 12-bit sampling converter: parallel byte port, serial port, AXI4-Lite registers.
`include "adc_readout_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R01: Format pin high straight binary, low two's complement
// R02: First conversion after power-up is invalid
// R03: Parallel reads never disturb the output register
// R04: Each serial bit clock shifts output register once; in external mode the first rise after each load only arms and does not shift
// R05: Host reads parallel before serial for both views
// R06: Internal mode start converts and sends previous result
// R07: External mode start converts, bit clock pin input
// R08: External mode shifts new result after busy rises
// R09: External mode shifts previous result during conversion
// R10: Host ends convert command before busy rises
// R11: Convert commands ignored while busy low
// R12: Parallel only: source high, bit clock low
// R13: Bus driven only for read high, select low
// R14: Half low: eight MSBs, top on bit 7
// R15: Half high: four LSBs, LSB on bit 4
// R16: Half select may toggle freely within conversion
// R17: Output register undefined right after power-up
// R18: Output register updated before busy rises
// R19: Full scale codes 7FF/FFF and 800/000
// R20: Midscale codes 000/800, below midscale FFF/7FF
// R21: Straight binary inverts two's complement MSB
// R22: Select and read/convert ORed, level triggered start
// R23: Internal mode twelve pulses MSB first, then low
// R24: External mode MSB valid first fall, second rise
// R25: Daisy-chain bits follow after twelve result bits
module adc_result_readout
	import adc_readout_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Host control pins
	input wire logic i_dev_select_n,
	input wire logic i_read_convert,
	input wire logic i_code_format_select,
	input wire logic i_bit_clock_source_select,
	input wire logic i_half_select,
	input wire logic i_daisy_in,
	// Serial bit clock pin, two-way
	input wire logic i_serial_bit_clock,
	output logic o_serial_bit_clock,
	output logic o_serial_bit_clock_oe,
	// Result outputs
	output logic o_serial_result_out,
	output logic [7:0] o_parallel_result_bus,
	output logic o_parallel_result_bus_oe,
	output logic o_busy_n,
	// Converter core result, two's complement
	input wire logic [11:0] i_sar_result,
	// AXI4-Lite slave
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);
	import adc_readout_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] pins_raw;
	logic [6:0] pins;
	logic cs_n;
	logic rc;
	logic fmt_sb;
	logic src_ext;
	logic half;
	logic tag;
	logic ext_clk;

	// Idle-high pins pass inverted, so a cleared synchroniser reads as idle and not as a start
	assign pins_raw = {~i_dev_select_n, ~i_read_convert, i_code_format_select,
		~i_bit_clock_source_select, i_half_select, i_daisy_in, i_serial_bit_clock};

	pin_sync #(
		.W(7)
	) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(pins_raw),
		.o_sync(pins)
	);

	assign cs_n = ~pins[6];
	assign rc = ~pins[5];
	assign fmt_sb = pins[4];
	assign src_ext = ~pins[3];
	assign half = pins[2];
	assign tag = pins[1];
	assign ext_clk = pins[0];

	// ----------------------------------------------------------------
	// Internal bit clock pacing
	// ----------------------------------------------------------------
	readout_state_type s_q;
	readout_state_type s_d;
	logic half_tick;

	bit_clock_divider #(
		.HALF(`BITCLK_HALF_CYCLES)
	) u_bit_clock_divider (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_run(s_q.int_run),
		.o_tick(half_tick)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic start_req;
	logic ext_rise;
	logic ext_out_mode;
	logic [11:0] shown;
	logic [31:0] status_word;
	logic wr_fire;

	always_comb begin
		s_d = s_q;
		// Level triggered: both low starts, whichever fell first
		start_req = ~cs_n & ~rc; // R22
		ext_rise = ext_clk & ~s_q.ext_clk_prev;
		ext_out_mode = src_ext & ~cs_n & rc;
		s_d.ext_clk_prev = ext_clk;

		// Conversion sequence
		unique case (s_q.state)
			CONV_IDLE: begin
				// Busy low never reaches here, so commands then are dropped
				if (start_req) begin // R11
					s_d.state = CONV_RUN;
					s_d.busy_n = 1'b0;
					s_d.conv_cnt = '0;
					if (!src_ext) begin // R06
						s_d.int_run = 1'b1;
						s_d.int_clk = 1'b0;
						s_d.shift_cnt = '0;
						s_d.tag_start = tag;
					end // R07
				end
			end
			CONV_RUN: begin
				s_d.conv_cnt = s_q.conv_cnt + 16'h0001;
				if ({1'b0, s_q.conv_cnt} + 17'h00001 >= {1'b0, s_q.conv_len}) begin
					s_d.state = CONV_LOAD;
				end
			end
			CONV_LOAD: begin
				// Hold the load until the internal transmission has finished
				if (!s_q.int_run) begin
					s_d.out_reg = i_sar_result; // R18
					s_d.shift_cnt = '0;
					s_d.ext_primed = 1'b0;
					if (s_q.conv_seen != 2'b10) begin
						s_d.conv_seen = s_q.conv_seen + 2'b01; // R02
					end
					s_d.state = CONV_RAISE;
				end
			end
			CONV_RAISE: begin
				// Busy rises one cycle after the register update
				s_d.state = CONV_IDLE;
				s_d.busy_n = 1'b1; // R18
			end
		endcase

		// Internal bit clock: twelve pulses, data moves while the clock is low
		if (s_q.int_run && half_tick) begin
			if (!s_q.int_clk) begin
				s_d.int_clk = 1'b1;
			end else begin
				s_d.int_clk = 1'b0;
				s_d.out_reg = {s_d.out_reg[10:0], s_q.tag_start}; // R04
				s_d.shift_cnt = s_q.shift_cnt + 4'h1;
				if (s_q.shift_cnt == 4'(`RESULT_BITS - 1)) begin
					s_d.int_run = 1'b0; // R23
				end
			end
		end

		// External bit clock: first rise only arms, later rises shift in daisy data
		if (ext_out_mode && ext_rise && s_q.state != CONV_LOAD) begin // R08 R09
			if (!s_q.ext_primed) begin
				s_d.ext_primed = 1'b1; // R24
			end else begin
				s_d.out_reg = {s_d.out_reg[10:0], tag}; // R25
				if (s_q.shift_cnt != 4'hF) begin
					s_d.shift_cnt = s_q.shift_cnt + 4'h1;
				end
			end
		end

		// Code format applied on the way out; the register itself stays two's complement
		shown = s_d.out_reg;
		shown[11] = s_d.out_reg[11] ^ fmt_sb; // R01 R19 R20 R21
		s_d.ser_out = (s_d.shift_cnt == 4'h0) ? shown[11] : s_d.out_reg[11];
		// Parallel view only reads the register
		if (!half) begin // R03 R16
			s_d.par_data = shown[11:4]; // R14
		end else begin
			s_d.par_data = {shown[3:0], 4'h0}; // R15
		end
		s_d.par_oe = rc & ~cs_n; // R13

		// ------------------------------------------------------------
		// AXI4-Lite write: address and data taken in either order
		// ------------------------------------------------------------
		if (i_awvalid && !s_q.aw_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = i_awaddr;
		end
		if (i_wvalid && !s_q.w_held && !s_q.bvalid) begin
			s_d.w_held = 1'b1;
			s_d.w_data = i_wdata;
			s_d.w_strb = i_wstrb;
		end
		wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
		if (wr_fire) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RESP_OKAY;
			if (s_q.aw_addr[7:2] == 6'(`REG_CTRL >> 2)) begin
				if (s_q.w_strb[0]) begin
					s_d.conv_len[7:0] = s_q.w_data[7:0];
				end
				if (s_q.w_strb[1]) begin
					s_d.conv_len[15:8] = s_q.w_data[15:8];
				end
			end else if (s_q.aw_addr[7:2] != 6'(`REG_STATUS >> 2) &&
				s_q.aw_addr[7:2] != 6'(`REG_RESULT >> 2)) begin
				s_d.bresp = `RESP_DECERR;
			end
		end
		if (s_q.bvalid && i_bready) begin
			s_d.bvalid = 1'b0;
		end

		// ------------------------------------------------------------
		// AXI4-Lite read
		// ------------------------------------------------------------
		status_word = '0;
		status_word[`ST_BUSY] = ~s_q.busy_n;
		status_word[`ST_RESULT_VALID] = s_q.conv_seen[1];
		status_word[`ST_EXT_CLOCK] = src_ext;
		status_word[`ST_SHIFT_LSB +: 4] = s_q.shift_cnt;
		if (i_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `RESP_OKAY;
			unique case (i_araddr[7:2])
				6'(`REG_CTRL >> 2): s_d.rdata = {16'h0000, s_q.conv_len};
				6'(`REG_STATUS >> 2): s_d.rdata = status_word;
				6'(`REG_RESULT >> 2): s_d.rdata = {20'h00000, s_q.out_reg};
				default: begin
					s_d.rdata = '0;
					s_d.rresp = `RESP_DECERR;
				end
			endcase
		end else if (s_q.rvalid && i_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
			s_q.state <= CONV_IDLE;
			s_q.busy_n <= 1'b1;
			s_q.conv_len <= 16'(`CONV_CYCLES);
			s_q.out_reg <= `OUT_REG_RESET; // R17
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_busy_n = s_q.busy_n;
	assign o_serial_result_out = s_q.ser_out;
	assign o_serial_bit_clock = s_q.int_clk;
	assign o_serial_bit_clock_oe = ~src_ext;
	assign o_parallel_result_bus = s_q.par_data;
	assign o_parallel_result_bus_oe = s_q.par_oe;
	assign o_awready = ~s_q.aw_held & ~s_q.bvalid;
	assign o_wready = ~s_q.w_held & ~s_q.bvalid;
	assign o_bvalid = s_q.bvalid;
	assign o_bresp = s_q.bresp;
	assign o_arready = ~s_q.rvalid;
	assign o_rvalid = s_q.rvalid;
	assign o_rdata = s_q.rdata;
	assign o_rresp = s_q.rresp;
endmodule // adc_result_readout

`default_nettype wire

// File: hw/adc_readout_cfg.svh
// Constants for the converter result readout block: offsets, fields, resets and timing.
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define CONV_TIME_NS 13500
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BITCLK_HALF_NS 556
`define BITCLK_HALF_CYCLES ((`BITCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_BITS 12

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESULT 8'h08
`define ST_BUSY 0
`define ST_RESULT_VALID 1
`define ST_EXT_CLOCK 2
`define ST_SHIFT_LSB 4
`define OUT_REG_RESET 12'h000
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// File: hw/adc_readout_pkg.sv
// Types shared by the converter result readout block.
package adc_readout_pkg;

	// ----------------------------------------------------------------
	// Conversion sequence, Gray coded along its path
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN = 2'b01,
		CONV_LOAD = 2'b11,
		CONV_RAISE = 2'b10
	} conv_state_type;

	// ----------------------------------------------------------------
	// Complete state of the readout block
	// ----------------------------------------------------------------
	typedef struct packed {
		conv_state_type state;
		logic busy_n;
		logic [15:0] conv_cnt;
		logic [15:0] conv_len;
		logic [11:0] out_reg;
		logic [3:0] shift_cnt;
		logic int_run;
		logic int_clk;
		logic tag_start;
		logic ext_clk_prev;
		logic ext_primed;
		logic [1:0] conv_seen;
		logic [7:0] par_data;
		logic par_oe;
		logic ser_out;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} readout_state_type;

endpackage

// File: hw/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Pins and their synchronised copies
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_type;

	sync_state_type s_q;
	sync_state_type s_d;

	// The first stage feeds only the second stage
	always_comb begin
		s_d.meta = i_async;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_sync = s_q.stable;
endmodule // pin_sync

`default_nettype wire

// File: hw/bit_clock_divider.sv
// Divider that gives one-cycle ticks for each half period of the internal bit clock.
`timescale 1ns/10ps
`default_nettype none

module bit_clock_divider #(
	parameter int HALF = 2
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Control and tick
	input wire logic i_run,
	output logic o_tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} div_state_type;

	div_state_type s_q;
	div_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!i_run) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == 16'(HALF - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick = s_q.tick;
endmodule // bit_clock_divider

`default_nettype wire

// File: bench/adc_readout_checker_sva.sv
// Concurrent checks on the pins of the converter result readout block.
`timescale 1ns/10ps
`default_nettype none

module adc_readout_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// Host pins
	input wire logic i_dev_select_n,
	input wire logic i_read_convert,
	input wire logic i_code_format_select,
	input wire logic i_half_select,
	input wire logic [11:0] i_sar_result,
	// Outputs
	input wire logic o_serial_bit_clock,
	input wire logic o_serial_bit_clock_oe,
	input wire logic o_serial_result_out,
	input wire logic [7:0] o_parallel_result_bus,
	input wire logic o_parallel_result_bus_oe,
	input wire logic o_busy_n
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	// ----------------------------------------------------------------
	// Pin effects lag by two sync stages and one register, hence depth 3
	// ----------------------------------------------------------------
	sequence conv_done;
		!o_busy_n ##1 o_busy_n;
	endsequence

	AST_BUS_GATE: assert property (o_parallel_result_bus_oe |-> $past(!i_dev_select_n && i_read_convert, 3))
		else $error("bus driven outside read select");
	AST_LOW_NIBBLE: assert property (o_parallel_result_bus_oe && $past(i_half_select, 3) |->
		o_parallel_result_bus[3:0] == 4'h0) else $error("low nibble not zero");
	AST_START: assert property ($fell(o_busy_n) |-> $past(!i_dev_select_n && !i_read_convert, 3))
		else $error("busy fell without start");
	AST_BUSY_MIN: assert property ($fell(o_busy_n) |-> !o_busy_n [*8])
		else $error("conversion ended too early");
	AST_IDLE_CLOCK: assert property (o_busy_n && o_serial_bit_clock_oe |-> !o_serial_bit_clock)
		else $error("bit clock not low between frames");
	AST_DATA_HOLD: assert property ($rose(o_serial_bit_clock) |-> $stable(o_serial_result_out))
		else $error("serial data moved at rising clock");
	AST_FIRST_PULSE: assert property ($fell(o_busy_n) && o_serial_bit_clock_oe |-> ##[1:200] o_serial_bit_clock)
		else $error("internal bit clock did not start");
	AST_NEW_RESULT: assert property (conv_done ##0 o_parallel_result_bus_oe && $past(!i_half_select, 3) |->
		o_parallel_result_bus == {$past(i_sar_result[11], 2) ^ $past(i_code_format_select, 3),
		$past(i_sar_result[10:4], 2)})
		else $error("bus not updated when busy rose");
endmodule // adc_readout_checker

`default_nettype wire

// File: bench/bit_clock_host.sv
// Host model that clocks one frame out of the serial port with its own bit clock.
`timescale 1ns/10ps
`default_nettype none

module bit_clock_host (
	// Control
	input wire logic i_go,
	// Serial port
	input wire logic i_serial_result_out,
	output logic o_sck,
	output logic [12:0] o_cap,
	output logic o_done
);
	// Phase offset keeps the bit clock unrelated to the core clock
	initial begin
		o_sck = 1'b0;
		o_cap = 13'h0000;
		o_done = 1'b0;
		@(posedge i_go);
		#37;
		repeat (13) begin
			o_sck = 1'b1;
			#80;
			o_sck = 1'b0;
			o_cap = {o_cap[11:0], i_serial_result_out};
			#80;
		end
		o_done = 1'b1;
	end
endmodule // bit_clock_host

`default_nettype wire

// File: bench/adc_result_readout_test.sv
// Self-checking bench for the converter result readout block.
`timescale 1ns/10ps
`default_nettype none
`include "adc_readout_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("Error at %0t got %h exp %h", $time, a, e); end end

module adc_result_readout_test;
	import adc_readout_pkg::*;
	logic i_core_clk = 1'b0, i_srst = 1'b1, i_dev_select_n = 1'b1, i_read_convert = 1'b1, i_half_select = 1'b0;
	logic i_code_format_select = 1'b0, i_bit_clock_source_select = 1'b1, i_daisy_in = 1'b1, go = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_parallel_result_bus;
	logic [31:0] i_wdata = 32'h00000000, o_rdata, d;
	logic [11:0] i_sar_result = 12'h000, e, icap;
	logic [3:0] i_wstrb = 4'hF;
	logic [1:0] o_bresp, o_rresp, r;
	logic [12:0] cap;
	logic i_serial_bit_clock, o_serial_bit_clock, o_serial_bit_clock_oe, o_serial_result_out, sck, sdone;
	logic o_parallel_result_bus_oe, o_busy_n, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	// Rows: format select, converter code, expected output code
	logic [24:0] rows [8] = '{25'h07FF7FF, 25'h17FFFFF, 25'h0800800, 25'h1800000, 25'h0000000, 25'h1000800,
		25'h0FFFFFF, 25'h1FFF7FF};
	int mismatches = 0, check_count = 0, cyc = 0, ipul = 0;

	adc_result_readout adc_result_readout_i (.i_core_clk, .i_srst, .i_dev_select_n, .i_read_convert,
		.i_code_format_select, .i_bit_clock_source_select, .i_half_select, .i_daisy_in, .i_serial_bit_clock,
		.o_serial_bit_clock, .o_serial_bit_clock_oe, .o_serial_result_out, .o_parallel_result_bus,
		.o_parallel_result_bus_oe, .o_busy_n, .i_sar_result, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
		.i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
		.o_rdata, .o_rresp);
	bit_clock_host bit_clock_host_i (.i_go(go), .i_serial_result_out(o_serial_result_out), .o_sck(sck), .o_cap(cap),
		.o_done(sdone));
	// Shared bit clock wire: the block drives it while its enable is up, the host's sck otherwise
	assign i_serial_bit_clock = o_serial_bit_clock_oe ? o_serial_bit_clock : sck;

	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	always @(posedge o_serial_bit_clock) begin
		icap = {icap[10:0], o_serial_result_out};
		ipul++;
	end

	// ----------------------------------------------------------------
	// Bus and pin tasks
	// ----------------------------------------------------------------
	task ax(input logic wr, input logic [7:0] a, input logic [31:0] v);
		@(posedge i_core_clk);
		i_awvalid <= wr;
		i_wvalid <= wr;
		i_bready <= wr;
		i_arvalid <= !wr;
		i_rready <= !wr;
		i_awaddr <= a;
		i_araddr <= a;
		i_wdata <= v;
		do begin
			@(posedge i_core_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_arready) i_arvalid <= 1'b0;
			if (i_bready && o_bvalid) begin
				r = o_bresp;
				i_bready <= 1'b0;
			end
			if (i_rready && o_rvalid) begin
				r = o_rresp;
				d = o_rdata;
				i_rready <= 1'b0;
			end
		end while (i_bready || i_rready);
	endtask

	// Start, drop the command once busy shows, then retry it while busy is low
	task cnv;
		@(posedge i_core_clk);
		i_dev_select_n <= 1'b0;
		i_read_convert <= 1'b0;
		do @(posedge i_core_clk); while (o_busy_n);
		i_read_convert <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		i_read_convert <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_read_convert <= 1'b1;
		do @(posedge i_core_clk); while (!o_busy_n);
		repeat (12) @(posedge i_core_clk);
		`CHK(o_busy_n, 1'b1)
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		`CHK(o_busy_n, 1'b1)
		`CHK(o_parallel_result_bus_oe, 1'b0)
		ax(1'b1, `REG_CTRL, 32'h00000014);
		`CHK(r, `RESP_OKAY)
		ax(1'b0, `REG_CTRL, 32'h00000000);
		`CHK(d[15:0], 16'h0014)
		ax(1'b1, 8'h40, 32'h00000000);
		`CHK(r, `RESP_DECERR)
		ax(1'b0, 8'h40, 32'h00000000);
		`CHK(r, `RESP_DECERR)
		$display("register test done");
		foreach (rows[n]) begin
			i_code_format_select <= rows[n][24];
			i_sar_result <= rows[n][23:12];
			e = rows[n][11:0];
			cnv();
			`CHK(o_parallel_result_bus_oe, 1'b1)
			`CHK(o_parallel_result_bus, e[11:4])
			i_half_select <= 1'b1;
			repeat (4) @(posedge i_core_clk);
			`CHK(o_parallel_result_bus, {e[3:0], 4'h0})
			i_half_select <= 1'b0;
			repeat (4) @(posedge i_core_clk);
			`CHK(o_parallel_result_bus, e[11:4])
			ax(1'b0, `REG_RESULT, 32'h00000000);
			`CHK(d[11:0], rows[n][23:12])
			ax(1'b0, `REG_STATUS, 32'h00000000);
			`CHK(d[1], n > 0)
		end
		i_dev_select_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		`CHK(o_parallel_result_bus_oe, 1'b0)
		$display("parallel test done");
		i_code_format_select <= 1'b0;
		i_sar_result <= 12'hA5C;
		cnv();
		`CHK(o_parallel_result_bus, 8'hA5)
		go <= 1'b1;
		wait (sdone);
		`CHK(cap[12:1], 12'hA5C)
		`CHK(cap[0], 1'b1)
		$display("external serial test done");
		i_bit_clock_source_select <= 1'b0;
		i_sar_result <= 12'h3C6;
		cnv();
		i_sar_result <= 12'h000;
		ipul = 0;
		cnv();
		`CHK(ipul, 12)
		`CHK(icap, 12'h3C6)
		`CHK(o_serial_bit_clock_oe, 1'b1)
		`CHK(o_serial_result_out, 1'b0)
		$display("internal serial test done");
		i_srst <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		i_srst <= 1'b0;
		ax(1'b0, `REG_STATUS, 32'h00000000);
		`CHK(d[1], 1'b0)
		`CHK(o_busy_n, 1'b1)
		$display("reset test done");
		test_done();
	end
endmodule // adc_result_readout_test

bind adc_result_readout adc_readout_checker adc_readout_checker_i (.i_core_clk, .i_srst, .i_dev_select_n,
	.i_read_convert, .i_code_format_select, .i_half_select, .i_sar_result, .o_serial_bit_clock,
	.o_serial_bit_clock_oe, .o_serial_result_out, .o_parallel_result_bus, .o_parallel_result_bus_oe, .o_busy_n);

`default_nettype wire
